// ---- hdl/stepper_cmd_pkg.sv ----
// Constants shared by both ends of the stepper command link.
// Assumes a single clock domain on both sides of the link.
`default_nettype none

package stepper_cmd_pkg;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FULL_STATUS_QUERY       = 8'h81;
	localparam logic [7:0] POSITION_QUERY          = 8'hfc;
	localparam logic [7:0] OTP_READBACK_QUERY      = 8'h82;
	localparam logic [7:0] GOTO_SAFE_POS_CMD       = 8'h84;
	localparam logic [7:0] IMMEDIATE_STOP_CMD      = 8'h85;
	localparam logic [7:0] ZERO_POSITION_CMD       = 8'h86;
	localparam logic [7:0] RELOAD_DEFAULTS_CMD     = 8'h87;
	localparam logic [7:0] REFERENCE_SEARCH_CMD    = 8'h88;
	localparam logic [7:0] WRITE_MOTION_PARAMS_CMD = 8'h89;
	localparam logic [7:0] PROGRAM_OTP_CMD         = 8'h90;
	localparam logic [7:0] WRITE_TARGET_CMD        = 8'h8b;
	localparam logic [7:0] DECELERATE_STOP_CMD     = 8'h8f;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_FIXED   = 2'h3;
	localparam logic [2:0] ID_FIXED     = 3'h7;
	localparam logic [4:0] SAFE_PAD     = 5'h1f;
	localparam logic [7:0] NA_BYTE      = 8'hff;
	localparam logic       RW_READ      = 1'h1;
	localparam logic       RW_WRITE     = 1'h0;
	localparam logic [1:0] HALF_STEP    = 2'h0;
	localparam logic [2:0] POS_LSB_MASK = 3'h0;
	localparam int         LAST_BYTE    = 8;
	localparam logic [3:0] B_ID         = 4'h1;
	localparam logic [3:0] B_2          = 4'h2;
	localparam logic [3:0] B_3          = 4'h3;
	localparam logic [3:0] B_4          = 4'h4;
	localparam logic [3:0] B_5          = 4'h5;
	localparam logic [3:0] B_6          = 4'h6;
	localparam logic [3:0] B_7          = 4'h7;

	typedef enum logic [1:0] {Q_NONE, Q_FULL, Q_POS, Q_OTP} query_t;
endpackage

`default_nettype wire

// ---- hdl/stepper_link_if.sv ----
// Byte-level link between the bus master and the stepper command slave.
// Assumes both ends run on the same clock; every signal is a one-cycle
// pulse or is qualified by one.
`default_nettype none

interface stepper_link_if;
	logic       frame_start;
	logic       wr_valid;
	logic [7:0] wr_byte;
	logic       rd_req;
	logic       rd_last;
	logic       rsp_valid;
	logic [7:0] rsp_byte;

	modport device (
		input  frame_start,
		input  wr_valid,
		input  wr_byte,
		input  rd_req,
		input  rd_last,
		output rsp_valid,
		output rsp_byte
	);
	modport host (
		output frame_start,
		output wr_valid,
		output wr_byte,
		output rd_req,
		output rd_last,
		input  rsp_valid,
		input  rsp_byte
	);
endinterface

`default_nettype wire

// ---- hdl/stepper_cmd_slave.sv ----
// Command decoder and status responder of the stepper controller.
// Assumes the motion core supplies parameters, flags and positions on
// REF_CLK and acts on the one-cycle command pulses.
//
// Summary of operation
// - Command byte selects status, position or OTP query
// - 0x84 safe, 0x85 hard stop, 0x8F soft
// - 0x86 zero, 0x87 reload, 0x90 program OTP
// - 0x88 reference, 0x89 params, 0x8B target
// - Address byte 11, OTP bits, pin, R/W
// - Byte 1 returns 111, OTP bits, pin for status and position queries
// - Not-applicable fields read as all ones
// - Full status returns seven-byte frame 0..6
// - Byte 2 run and hold current
// - Byte 3 top and floor velocity
// - Byte 4 shape, resolution, direction, rate
// - Byte 5 fault flags and temperature level
// - Byte 6 motion, switch, overcurrents, 1, pump
// - Bytes 2,3 actual position high first
// - Half stepping clears three position LSBs
// - Bytes 4..7 target and safe positions
// - Address LSB 1 reads, 0 writes
// - Master writes command, then separate read frame
// - Master leaves final byte unacknowledged
`default_nettype none

module stepper_cmd_slave (
	input  wire logic              REF_CLK,
	input  wire logic              RESET,
	stepper_link_if.device         link,
	input  wire logic [3:0]        OTP_ADDR,
	input  wire logic              HARDWIRED_ADDRESS_PIN,
	input  wire logic [3:0]        RUN_CURRENT,
	input  wire logic [3:0]        HOLD_CURRENT,
	input  wire logic [3:0]        TOP_VELOCITY,
	input  wire logic [3:0]        FLOOR_VELOCITY,
	input  wire logic              RAMP_SHAPE,
	input  wire logic [1:0]        MICROSTEP_RESOLUTION,
	input  wire logic              ROTATION_DIR,
	input  wire logic [3:0]        RAMP_RATE,
	input  wire logic [5:0]        FAULT_FLAGS,
	input  wire logic [1:0]        TEMPERATURE_LEVEL,
	input  wire logic [2:0]        MOTION_STATE,
	input  wire logic              EXTERNAL_SWITCH_STATE,
	input  wire logic              COIL_A_OVERCURRENT,
	input  wire logic              COIL_B_OVERCURRENT,
	input  wire logic              PUMP_FAILURE_FLAG,
	input  wire logic [15:0]       CURRENT_POSITION,
	input  wire logic [15:0]       TARGET_POSITION,
	input  wire logic [10:0]       SAFE_POSITION,
	input  wire logic [63:0]       OTP_CONTENTS,
	output logic                   GOTO_SAFE_POS_CMD,
	output logic                   IMMEDIATE_STOP_CMD,
	output logic                   DECELERATE_STOP_CMD,
	output logic                   ZERO_POSITION_CMD,
	output logic                   RELOAD_DEFAULTS_CMD,
	output logic                   PROGRAM_OTP_CMD,
	output logic                   REFERENCE_SEARCH_CMD,
	output logic                   WRITE_MOTION_PARAMS_CMD,
	output logic                   WRITE_TARGET_CMD
);
	// ----------------------------------------------------------------
	// Address pin capture
	// ----------------------------------------------------------------
	// The address pin is strapped through a resistor, so it is treated
	// as asynchronous and passes two flops before use.
	logic       hw_meta;
	logic       hw_pin;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			hw_meta <= 1'b0;
			hw_pin  <= 1'b0;
		end else begin
			hw_meta <= HARDWIRED_ADDRESS_PIN;
			hw_pin  <= hw_meta;
		end
	end

	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_CMD, S_READ, S_SKIP} state_t;

	state_t                   state;
	stepper_cmd_pkg::query_t  query;
	logic [3:0]               index;
	logic                     addr_hit;
	logic                     cmd_seen;
	logic [7:0]               cmd_code;

	assign addr_hit = link.wr_byte[7:6] == stepper_cmd_pkg::ADDR_FIXED
		&& link.wr_byte[5:1] == {OTP_ADDR, hw_pin};

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state <= S_IDLE;
		end else if (link.frame_start && link.wr_valid) begin
			if (!addr_hit)
				state <= S_SKIP;
			else if (link.wr_byte[0] == stepper_cmd_pkg::RW_READ)
				state <= S_READ;
			else
				state <= S_CMD;
		end else begin
			case (state)
				S_CMD: begin
					if (link.wr_valid)
						state <= S_SKIP;
				end
				S_READ: begin
					if (link.rd_req && link.rd_last)
						state <= S_IDLE;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cmd_seen <= 1'b0;
			cmd_code <= 8'h00;
		end else begin
			cmd_seen <= state == S_CMD && link.wr_valid
				&& !link.frame_start;
			cmd_code <= link.wr_byte;
		end
	end

	// ----------------------------------------------------------------
	// Query selection
	// ----------------------------------------------------------------
	// The query survives until the next query command so that a response
	// frame may be read more than once.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			query <= stepper_cmd_pkg::Q_NONE;
		end else if (cmd_seen) begin
			case (cmd_code)
				stepper_cmd_pkg::FULL_STATUS_QUERY:
					query <= stepper_cmd_pkg::Q_FULL;
				stepper_cmd_pkg::POSITION_QUERY:
					query <= stepper_cmd_pkg::Q_POS;
				stepper_cmd_pkg::OTP_READBACK_QUERY:
					query <= stepper_cmd_pkg::Q_OTP;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command pulses
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			GOTO_SAFE_POS_CMD       <= 1'b0;
			IMMEDIATE_STOP_CMD      <= 1'b0;
			DECELERATE_STOP_CMD     <= 1'b0;
			ZERO_POSITION_CMD       <= 1'b0;
			RELOAD_DEFAULTS_CMD     <= 1'b0;
			PROGRAM_OTP_CMD         <= 1'b0;
			REFERENCE_SEARCH_CMD    <= 1'b0;
			WRITE_MOTION_PARAMS_CMD <= 1'b0;
			WRITE_TARGET_CMD        <= 1'b0;
		end else begin
			GOTO_SAFE_POS_CMD   <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::GOTO_SAFE_POS_CMD;
			IMMEDIATE_STOP_CMD  <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::IMMEDIATE_STOP_CMD;
			DECELERATE_STOP_CMD <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::DECELERATE_STOP_CMD;
			ZERO_POSITION_CMD   <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::ZERO_POSITION_CMD;
			RELOAD_DEFAULTS_CMD <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::RELOAD_DEFAULTS_CMD;
			PROGRAM_OTP_CMD     <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::PROGRAM_OTP_CMD;
			REFERENCE_SEARCH_CMD    <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::REFERENCE_SEARCH_CMD;
			WRITE_MOTION_PARAMS_CMD <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::WRITE_MOTION_PARAMS_CMD;
			WRITE_TARGET_CMD        <= cmd_seen
				&& cmd_code == stepper_cmd_pkg::WRITE_TARGET_CMD;
			// any other code raises no pulse
		end
	end

	// ----------------------------------------------------------------
	// Response bytes
	// ----------------------------------------------------------------
	logic [15:0] pos_report;
	logic [7:0]  next_rsp;

	assign pos_report = MICROSTEP_RESOLUTION == stepper_cmd_pkg::HALF_STEP
		? {CURRENT_POSITION[15:3], stepper_cmd_pkg::POS_LSB_MASK}
		: CURRENT_POSITION;

	always_comb begin
		next_rsp = stepper_cmd_pkg::NA_BYTE;
		if (query == stepper_cmd_pkg::Q_OTP) begin
			if (index != 4'h0 && int'(index) <= stepper_cmd_pkg::LAST_BYTE)
				next_rsp = OTP_CONTENTS[8 * (index - 4'h1) +: 8];
		end else if (query != stepper_cmd_pkg::Q_NONE) begin
			case (index)
				stepper_cmd_pkg::B_ID:
					next_rsp = {stepper_cmd_pkg::ID_FIXED, OTP_ADDR, hw_pin};
				default: ;
			endcase
			if (query == stepper_cmd_pkg::Q_FULL) begin
				case (index)
					stepper_cmd_pkg::B_2:
						next_rsp = {RUN_CURRENT, HOLD_CURRENT};
					stepper_cmd_pkg::B_3:
						next_rsp = {TOP_VELOCITY, FLOOR_VELOCITY};
					stepper_cmd_pkg::B_4:
						next_rsp = {RAMP_SHAPE, MICROSTEP_RESOLUTION,
							ROTATION_DIR, RAMP_RATE};
					stepper_cmd_pkg::B_5:
						next_rsp = {FAULT_FLAGS, TEMPERATURE_LEVEL};
					stepper_cmd_pkg::B_6:
						next_rsp = {MOTION_STATE, EXTERNAL_SWITCH_STATE,
							COIL_A_OVERCURRENT, COIL_B_OVERCURRENT, 1'b1,
							PUMP_FAILURE_FLAG};
					default: ;
				endcase
			end else begin
				case (index)
					stepper_cmd_pkg::B_2: next_rsp = pos_report[15:8];
					stepper_cmd_pkg::B_3: next_rsp = pos_report[7:0];
					stepper_cmd_pkg::B_4: next_rsp = TARGET_POSITION[15:8];
					stepper_cmd_pkg::B_5: next_rsp = TARGET_POSITION[7:0];
					stepper_cmd_pkg::B_6: next_rsp = SAFE_POSITION[7:0];
					stepper_cmd_pkg::B_7:
						next_rsp = {stepper_cmd_pkg::SAFE_PAD,
							SAFE_POSITION[10:8]};
					default: ;
				endcase
			end
		end
	end

	// bytes 1..15 follow the address byte, the count holding at 15
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			index <= 4'h0;
		end else if (link.frame_start && link.wr_valid) begin
			index <= stepper_cmd_pkg::B_ID;
		end else if (state == S_READ && link.rd_req && index != 4'hf) begin
			index <= index + 4'h1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			link.rsp_valid <= 1'b0;
			link.rsp_byte  <= 8'h00;
		end else begin
			link.rsp_valid <= state == S_READ && link.rd_req;
			link.rsp_byte  <= next_rsp;
		end
	end
endmodule

`default_nettype wire

// ---- hdl/stepper_cmd_master.sv ----
// Bus master end: sends one command, optionally reads the response.
// Assumes the user holds request fields steady while START is high and
// waits for DONE before the next START.
`default_nettype none

module stepper_cmd_master #(
	parameter int MAX_READ = 8
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	stepper_link_if.host     link,
	input  wire logic        START,
	input  wire logic [7:0]  CMD_CODE,
	input  wire logic [4:0]  SLAVE_SEL,
	input  wire logic [3:0]  READ_COUNT,
	output logic             BUSY,
	output logic             RD_VALID,
	output logic [7:0]       RD_DATA,
	output logic             DONE
);
	// The read counter is four bits wide
	if (MAX_READ < 1 || MAX_READ > 15) begin
		$error("MAX_READ must lie in 1..15");
	end

	typedef enum logic [2:0] {
		M_IDLE, M_CMD, M_RADDR, M_REQ, M_WAIT
	} state_t;

	state_t      state;
	logic [7:0]  code;
	logic [4:0]  sel;
	logic [3:0]  left;
	logic        late;
	logic        give_up;

	// A slave answers one cycle after a request; silence means nobody
	// owns the address, so the transfer is dropped instead of hanging.
	assign give_up = state == M_WAIT && !link.rsp_valid && late;

	always_ff @(posedge REF_CLK) begin
		if (RESET)
			late <= 1'b0;
		else
			late <= state == M_WAIT && !link.rsp_valid && !late;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state <= M_IDLE;
			code  <= 8'h00;
			sel   <= 5'h00;
			left  <= 4'h0;
		end else begin
			case (state)
				M_IDLE: begin
					if (START) begin
						code  <= CMD_CODE;
						sel   <= SLAVE_SEL;
						left  <= READ_COUNT > 4'(MAX_READ)
							? 4'(MAX_READ) : READ_COUNT;
						state <= M_CMD;
					end
				end
				// read frame follows the write frame
				M_CMD:   state <= left == 4'h0 ? M_IDLE : M_RADDR;
				M_RADDR: state <= M_REQ;
				M_REQ:   state <= M_WAIT;
				M_WAIT: begin
					if (link.rsp_valid) begin
						left  <= left - 4'h1;
						state <= left == 4'h1 ? M_IDLE : M_REQ;
					end else if (late) begin
						state <= M_IDLE;
					end
				end
				default: state <= M_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Link drive
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			link.frame_start <= 1'b0;
			link.wr_valid    <= 1'b0;
			link.wr_byte     <= 8'h00;
			link.rd_req      <= 1'b0;
			link.rd_last     <= 1'b0;
		end else begin
			link.frame_start <= 1'b0;
			link.wr_valid    <= 1'b0;
			link.rd_req      <= 1'b0;
			link.rd_last     <= 1'b0;
			if (state == M_IDLE && START) begin
				link.frame_start <= 1'b1;
				link.wr_valid    <= 1'b1;
				link.wr_byte     <= {stepper_cmd_pkg::ADDR_FIXED, SLAVE_SEL,
					stepper_cmd_pkg::RW_WRITE};
			end else if (state == M_CMD) begin
				link.wr_valid <= 1'b1;
				link.wr_byte  <= code;
			end else if (state == M_RADDR) begin
				link.frame_start <= 1'b1;
				link.wr_valid    <= 1'b1;
				link.wr_byte     <= {stepper_cmd_pkg::ADDR_FIXED, sel,
					stepper_cmd_pkg::RW_READ};
			end else if (state == M_REQ) begin
				link.rd_req  <= 1'b1;
				link.rd_last <= left == 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// User side
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			BUSY     <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA  <= 8'h00;
			DONE     <= 1'b0;
		end else begin
			BUSY     <= (state != M_IDLE || START)
				&& !(state == M_CMD && left == 4'h0)
				&& !(state == M_WAIT && link.rsp_valid && left == 4'h1)
				&& !give_up;
			RD_VALID <= state == M_WAIT && link.rsp_valid;
			RD_DATA  <= link.rsp_byte;
			DONE     <= (state == M_CMD && left == 4'h0)
				|| (state == M_WAIT && link.rsp_valid && left == 4'h1)
				|| give_up;
		end
	end
endmodule

`default_nettype wire

// ---- verification/stepper_link_chk.sv ----
// Assertion checker for the byte link joining master and slave ends.
// Assumes only master and slave drive the link, all on one clock.
`default_nettype none

module stepper_link_chk (
	input wire logic       REF_CLK,
	input wire logic       RESET,
	input wire logic       frame_start,
	input wire logic       wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic       rd_req,
	input wire logic       rd_last,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	logic       rdf;
	logic [7:0] adr;
	logic [7:0] q;
	logic [3:0] idx;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rdf <= 1'b0;
			adr <= 8'h00;
		end else if (frame_start) begin
			rdf <= wr_byte[0];
			adr <= wr_byte;
		end
	end

	// Only query codes change what the slave reads back
	always_ff @(posedge REF_CLK) begin
		if (RESET)
			q <= 8'h00;
		else if (wr_valid && !frame_start && !rdf && (wr_byte == 8'h81 ||
				wr_byte == 8'hfc || wr_byte == 8'h82))
			q <= wr_byte;
	end

	// Counts responses already seen in this frame, saturating
	always_ff @(posedge REF_CLK) begin
		if (RESET || frame_start)
			idx <= 4'h0;
		else if (rsp_valid && idx != 4'hf)
			idx <= idx + 4'h1;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	a_addr_high_ones: assert property (
		frame_start |-> wr_valid && wr_byte[7:6] == 2'b11)
		else $error("address byte malformed");
	a_cmd_after_waddr: assert property (
		wr_valid && !frame_start |-> $past(frame_start && !wr_byte[0]))
		else $error("command byte not after write address");
	a_read_after_cmd: assert property (
		frame_start && wr_byte[0] |-> $past(wr_valid && !frame_start))
		else $error("read frame without preceding command");
	a_req_in_read: assert property (
		rd_req |-> rdf && !wr_valid)
		else $error("read request outside read frame");
	a_rsp_after_req: assert property (
		rsp_valid |-> $past(rd_req))
		else $error("response without request");
	a_rsp_unqueried: assert property (
		rsp_valid && q == 8'h00 |-> rsp_byte == 8'hff)
		else $error("read before query not all ones");
	a_rsp_id_byte: assert property (
		rsp_valid && idx == 4'h0 && (q == 8'h81 || q == 8'hfc)
		|-> rsp_byte == {3'b111, adr[5:1]})
		else $error("identity byte wrong");
	a_status_tail: assert property (
		rsp_valid && q != 8'h82 && (idx >= 4'h7 || (idx == 4'h6 && q == 8'h81))
		|-> rsp_byte == 8'hff)
		else $error("unused byte not all ones");
	a_safe_pad: assert property (
		rsp_valid && q == 8'hfc && idx == 4'h6 |-> rsp_byte[7:3] == 5'h1f)
		else $error("safe position pad wrong");
	a_status_one: assert property (
		rsp_valid && q == 8'h81 && idx == 4'h5 |-> rsp_byte[1])
		else $error("status bit one missing");
	a_last_no_more: assert property (
		rd_req && rd_last |=> !rd_req [*3])
		else $error("request after final byte");

	c_full: cover property (rsp_valid && q == 8'h81 && idx == 4'h7);
	c_pos: cover property (rsp_valid && q == 8'hfc && idx == 4'h6);
	c_last: cover property (rd_req && rd_last);
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench: master and slave ends joined by the link.
// Assumes the bench alone drives both user sides at 200 MHz.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic        start;
	logic [7:0]  cmd;
	logic [4:0]  sel;
	logic [3:0]  cnt;
	logic        busy;
	logic        rd_valid;
	logic [7:0]  rd_data;
	logic        done;
	logic [3:0]  otp_addr;
	logic        hw_pin;
	logic [39:0] prm;
	logic [15:0] cur_pos;
	logic [15:0] tgt_pos;
	logic [10:0] safe_pos;
	logic [63:0] otp;
	logic [8:0]  pulse;
	logic [8:0]  seen;
	logic [15:0] a;
	logic [7:0]  id;
	logic [7:0]  got [1:15];
	logic [7:0]  exp_b [1:10];
	logic [7:0]  codes [0:8] = '{8'h84, 8'h85, 8'h8f, 8'h86, 8'h87, 8'h90,
		8'h88, 8'h89, 8'h8b};
	int          nrx;
	int          i;
	int          p;
	int          fail_count;
	int          checks_done;

	stepper_link_if stepper_link_if_inst ();

	// Status fields packed so bytes 2 to 6 map onto prm directly, except the fixed one in bit 1 of byte 6
	stepper_cmd_slave stepper_cmd_slave_inst (.REF_CLK(clk), .RESET(rst),
		.link(stepper_link_if_inst), .OTP_ADDR(otp_addr),
		.HARDWIRED_ADDRESS_PIN(hw_pin), .RUN_CURRENT(prm[39:36]),
		.HOLD_CURRENT(prm[35:32]), .TOP_VELOCITY(prm[31:28]),
		.FLOOR_VELOCITY(prm[27:24]), .RAMP_SHAPE(prm[23]),
		.MICROSTEP_RESOLUTION(prm[22:21]), .ROTATION_DIR(prm[20]),
		.RAMP_RATE(prm[19:16]), .FAULT_FLAGS(prm[15:10]),
		.TEMPERATURE_LEVEL(prm[9:8]), .MOTION_STATE(prm[7:5]),
		.EXTERNAL_SWITCH_STATE(prm[4]), .COIL_A_OVERCURRENT(prm[3]),
		.COIL_B_OVERCURRENT(prm[2]), .PUMP_FAILURE_FLAG(prm[0]),
		.CURRENT_POSITION(cur_pos), .TARGET_POSITION(tgt_pos),
		.SAFE_POSITION(safe_pos), .OTP_CONTENTS(otp),
		.GOTO_SAFE_POS_CMD(pulse[0]), .IMMEDIATE_STOP_CMD(pulse[1]),
		.DECELERATE_STOP_CMD(pulse[2]), .ZERO_POSITION_CMD(pulse[3]),
		.RELOAD_DEFAULTS_CMD(pulse[4]), .PROGRAM_OTP_CMD(pulse[5]),
		.REFERENCE_SEARCH_CMD(pulse[6]), .WRITE_MOTION_PARAMS_CMD(pulse[7]),
		.WRITE_TARGET_CMD(pulse[8]));

	stepper_cmd_master #(.MAX_READ(10)) stepper_cmd_master_inst (
		.REF_CLK(clk), .RESET(rst), .link(stepper_link_if_inst),
		.START(start), .CMD_CODE(cmd), .SLAVE_SEL(sel), .READ_COUNT(cnt),
		.BUSY(busy), .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done));

	stepper_link_chk stepper_link_chk_inst (.REF_CLK(clk), .RESET(rst),
		.frame_start(stepper_link_if_inst.frame_start),
		.wr_valid(stepper_link_if_inst.wr_valid),
		.wr_byte(stepper_link_if_inst.wr_byte),
		.rd_req(stepper_link_if_inst.rd_req),
		.rd_last(stepper_link_if_inst.rd_last),
		.rsp_valid(stepper_link_if_inst.rsp_valid),
		.rsp_byte(stepper_link_if_inst.rsp_byte));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
		checks_done++;
		if (seen_v !== exp_v) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic test_done;
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One command frame, then n response reads; with n of 0 the pulses land after DONE
	task automatic xfer(input logic [7:0] c, input logic [3:0] n,
		input logic [4:0] s);
		int w;
		@(posedge clk);
		start <= 1'b1;
		cmd <= c;
		sel <= s;
		cnt <= n;
		@(posedge clk);
		start <= 1'b0;
		nrx = 0;
		seen = '0;
		for (w = 0; w < 40; w++) begin
			@(posedge clk);
			#1;
			seen = seen | pulse;
			if (rd_valid === 1'b1) begin
				nrx++;
				got[nrx] = rd_data;
			end
			if (done === 1'b1)
				break;
		end
		chk(16'({busy, done}), 16'h1);
		repeat (2) begin
			@(posedge clk);
			#1;
			seen = seen | pulse;
		end
	endtask

	task automatic cmp_frame(input int n);
		chk(16'(nrx), 16'(n));
		for (int k = 1; k <= n; k++)
			chk(got[k], exp_b[k]);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		cmd = 8'h00;
		sel = 5'h00;
		cnt = 4'h0;
		otp_addr = 4'ha;
		hw_pin = 1'b1;
		prm = 40'h5ac3b6a5e9;
		cur_pos = 16'hc3b7;
		tgt_pos = 16'h7e81;
		safe_pos = 11'h5a6;
		otp = 64'h0123456789abcdef;
		fail_count = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({busy, rd_valid, done, pulse}, 16'h0);
		xfer(8'h85, 4'h3, {otp_addr, hw_pin});
		chk(16'(nrx), 16'h3);
		for (i = 1; i <= 3; i++)
			chk(got[i], 8'hff);
		for (i = 0; i < 9; i++) begin
			xfer(codes[i], 4'h0, {otp_addr, hw_pin});
			chk(seen, 16'h1 << i);
		end
		xfer(8'h83, 4'h0, {otp_addr, hw_pin});
		chk(seen, 16'h0);
		xfer(8'h85, 4'h2, {otp_addr, ~hw_pin});
		chk({seen, 7'(nrx)}, 16'h0);
		for (p = 0; p < 2; p++) begin
			@(posedge clk);
			prm <= p ? ~40'h5ac3b6a5e9 : 40'h5ac3b6a5e9;
			otp_addr <= p ? 4'h5 : 4'ha;
			hw_pin <= p ? 1'b0 : 1'b1;
			// Pin value reaches the address match two edges late
			repeat (3) @(posedge clk);
			#1;
			id = {3'b111, otp_addr, hw_pin};
			exp_b = '{id, prm[39:32], prm[31:24], prm[23:16], prm[15:8],
				{prm[7:2], 1'b1, prm[0]}, 8'hff, 8'hff, 8'hff, 8'hff};
			xfer(8'h81, 4'ha, {otp_addr, hw_pin});
			cmp_frame(10);
			xfer(8'h83, 4'h3, {otp_addr, hw_pin});
			cmp_frame(3);
		end
		for (p = 0; p < 2; p++) begin
			@(posedge clk);
			prm[22:21] <= p ? 2'b00 : 2'b01;
			@(posedge clk);
			#1;
			a = cur_pos & (prm[22:21] == 2'b00 ? 16'hfff8 : 16'hffff);
			exp_b = '{id, a[15:8], a[7:0], tgt_pos[15:8], tgt_pos[7:0],
				safe_pos[7:0], {5'h1f, safe_pos[10:8]}, 8'hff, 8'hff, 8'hff};
			xfer(8'hfc, 4'ha, {otp_addr, hw_pin});
			cmp_frame(10);
		end
		for (i = 1; i <= 10; i++)
			exp_b[i] = (i <= 8) ? otp[8 * (i - 1) +: 8] : 8'hff;
		xfer(8'h82, 4'ha, {otp_addr, hw_pin});
		cmp_frame(10);
		test_done();
	end
endmodule

`default_nettype wire
